// [src/fat_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fat_top #(
    parameter int ADDR_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic fetch_valid,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic low_speed_mode_one,
    output logic fetch_trap_irq,
    output logic reset_pin_n_o,
    output logic reset_pin_oe,
    output logic internal_reset,
    output logic fast_osc_restart,
    output logic guard_counter_clear,
    output logic guard_running,
    output logic irq
);
    localparam int CW = $clog2(fat_pkg::FAT_RST_CYCLES + 1);
    localparam logic [CW-1:0] RST_LEN = CW'(fat_pkg::FAT_RST_CYCLES);

    logic [7:0] ctrl_reg;
    logic ram_sel_live_reg;
    logic guard_run_reg;
    logic clr_pulse_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic irq_pend_reg;
    logic [CW-1:0] rcnt_reg;
    logic osc_reg;
    logic [fat_pkg::FAT_ST_W-1:0] stat_reg;
    logic [fat_pkg::FAT_ST_W-1:0] mask_reg;

    fat_trap_if tif ();
    assign tif.fetch_valid = fetch_valid;
    assign tif.fetch_addr = 16'(fetch_addr);
    assign tif.ram_trap_select = ram_sel_live_reg;

    fat_detect u_det (
        .t(tif.det)
    );

    wire req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire [1:0] widx = wb_adr_i[3:2];
    wire wr_ctrl = wr && widx == fat_pkg::FAT_ADR_CTRL;
    wire wr_code = wr && widx == fat_pkg::FAT_ADR_CODE;
    wire wr_stat = wr && widx == fat_pkg::FAT_ADR_STAT;
    wire wr_mask = wr && widx == fat_pkg::FAT_ADR_MASK;
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire code_commit = wr_code && wbyte == fat_pkg::FAT_CODE_COMMIT;
    wire code_clear = wr_code && wbyte == fat_pkg::FAT_CODE_CLEAR;
    wire code_dis = wr_code && wbyte == fat_pkg::FAT_CODE_DISABLE;
    wire guard_en = ctrl_reg[fat_pkg::FAT_BIT_GEN];
    wire action = ctrl_reg[fat_pkg::FAT_BIT_ACTION];
    wire in_reset = rcnt_reg != '0;
    wire trap_ok = tif.trap && !in_reset;
    wire trap_irq = trap_ok && !action;
    wire trap_rst = trap_ok && action;
    wire [fat_pkg::FAT_ST_W-1:0] ev = {code_clear, trap_rst, trap_irq};
    wire [31:0] rd_mux =
        widx == fat_pkg::FAT_ADR_STAT ? 32'(stat_reg) :
        widx == fat_pkg::FAT_ADR_MASK ? 32'(mask_reg) :
        32'h00000000; // write-only guard registers read as zero

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_reg <= fat_pkg::FAT_CTRL_RESET;
            ram_sel_live_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wbyte;
            end
            // select acts only once committed
            if (code_commit) begin
                ram_sel_live_reg <= ctrl_reg[fat_pkg::FAT_BIT_RAMSEL];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            guard_run_reg <= 1'b1;
            clr_pulse_reg <= 1'b0;
        end else begin
            clr_pulse_reg <= code_clear;
            if (code_dis && !guard_en) begin
                guard_run_reg <= 1'b0;
            end else if (wr_ctrl && wbyte[fat_pkg::FAT_BIT_GEN]) begin
                guard_run_reg <= 1'b1;
            end
        end
    end

    // non-maskable: held for one cycle after the trap, no enable gating
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_pend_reg <= 1'b0;
        end else begin
            irq_pend_reg <= trap_irq;
        end
    end

    // trap reset counter; rst clears a pulse in flight to zero at the next mclk edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            rcnt_reg <= '0;
            osc_reg <= 1'b0;
        end else if (trap_rst) begin
            rcnt_reg <= RST_LEN;
            osc_reg <= low_speed_mode_one;
        end else if (in_reset) begin
            rcnt_reg <= rcnt_reg - CW'(1);
        end else begin
            osc_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_reg <= '0;
            mask_reg <= '0;
        end else begin
            // set wins over write-one-to-clear
            stat_reg <= (stat_reg & ~(wr_stat ? wbyte[fat_pkg::FAT_ST_W-1:0]
                : '0)) | ev;
            if (wr_mask) begin
                mask_reg <= wbyte[fat_pkg::FAT_ST_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= req;
            rdata_reg <= rd_mux;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign fetch_trap_irq = trap_irq || irq_pend_reg;
    assign reset_pin_n_o = 1'b0;
    assign reset_pin_oe = in_reset;
    assign internal_reset = in_reset;
    assign fast_osc_restart = osc_reg;
    assign guard_counter_clear = clr_pulse_reg;
    assign guard_running = guard_run_reg;
    assign irq = |(stat_reg & mask_reg);

    // pulse length counted here; a repetition cannot stretch a pulse past 24 cycles
    logic [CW-1:0] oe_len_reg;
    logic oe_prev_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            oe_len_reg <= '0;
            oe_prev_reg <= 1'b0;
        end else begin
            oe_prev_reg <= reset_pin_oe;
            if (reset_pin_oe) begin
                oe_len_reg <= oe_len_reg + CW'(1);
            end else begin
                oe_len_reg <= '0;
            end
        end
    end

    // bus side
    AST_ACK_ONE: assert property (@(posedge mclk)
        disable iff (rst) wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_REQ: assert property (@(posedge mclk)
        disable iff (rst) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_CTRL_WR: assert property (@(posedge mclk)
        disable iff (rst) wr_ctrl |=> ctrl_reg == $past(wbyte))
        else $error("control byte not stored");
    AST_RD_ZERO: assert property (@(posedge mclk)
        disable iff (rst)
        wb_ack_o && !wb_we_i && widx == fat_pkg::FAT_ADR_CTRL |-> wb_dat_o == '0)
        else $error("write-only register read back");
    AST_MASK_OFF: assert property (@(posedge mclk)
        disable iff (rst) mask_reg == '0 |-> !irq)
        else $error("masked status raised irq");

    // codes
    AST_COMMIT: assert property (@(posedge mclk)
        disable iff (rst) code_commit |=> ram_sel_live_reg ==
        $past(ctrl_reg[fat_pkg::FAT_BIT_RAMSEL]))
        else $error("ram select not committed");
    AST_NO_COMMIT: assert property (@(posedge mclk)
        disable iff (rst) !code_commit |=> $stable(ram_sel_live_reg))
        else $error("ram select changed without code");
    AST_BAD_CODE: assert property (@(posedge mclk)
        disable iff (rst) wr_code && !code_commit && !code_clear && !code_dis
        |=> $stable(ram_sel_live_reg) && $stable(guard_run_reg)
        && !guard_counter_clear)
        else $error("unknown code acted");
    AST_CLEAR: assert property (@(posedge mclk)
        disable iff (rst) code_clear |=> guard_counter_clear)
        else $error("clear code lost");
    AST_CLR_ONE: assert property (@(posedge mclk)
        disable iff (rst) guard_counter_clear |=> !guard_counter_clear)
        else $error("clear pulse too long");
    AST_DIS: assert property (@(posedge mclk)
        disable iff (rst)
        code_dis && guard_en && !wr_ctrl |=> $stable(guard_run_reg))
        else $error("disable acted while enabled");
    AST_DIS_OK: assert property (@(posedge mclk)
        disable iff (rst) code_dis && !guard_en |=> !guard_running)
        else $error("disable code ignored");
    AST_RUN_FALL: assert property (@(posedge mclk)
        disable iff (rst) $fell(guard_running) |-> $past(code_dis && !guard_en))
        else $error("guard stopped without disable code");

    // trap detection and action
    AST_SAME_CYCLE: assert property (@(posedge mclk)
        disable iff (rst)
        tif.fetch_valid && tif.fetch_addr <= fat_pkg::FAT_SFR_HI |-> tif.trap)
        else $error("fetch not flagged in its cycle");
    AST_SFR: assert property (@(posedge mclk)
        disable iff (rst)
        tif.hit_sfr && !in_reset && !action |-> fetch_trap_irq)
        else $error("sfr fetch did not trap");
    AST_RAM_OFF: assert property (@(posedge mclk)
        disable iff (rst)
        tif.hit_ram && !ram_sel_live_reg && !tif.hit_sfr |-> !tif.trap)
        else $error("ram fetch trapped while off");
    AST_RAM_ON: assert property (@(posedge mclk)
        disable iff (rst) tif.hit_ram && ram_sel_live_reg |-> tif.trap)
        else $error("ram fetch missed while on");
    AST_ACT_IRQ: assert property (@(posedge mclk)
        disable iff (rst) trap_ok && !action |-> !trap_rst)
        else $error("interrupt action gave reset");
    AST_ACTION: assert property (@(posedge mclk)
        disable iff (rst) trap_ok && action |-> !trap_irq ##1 reset_pin_oe)
        else $error("reset action wrong");
    AST_IRQ_HOLD: assert property (@(posedge mclk)
        disable iff (rst) trap_irq |=> fetch_trap_irq)
        else $error("trap request not held");
    AST_IRQ_CAUSE: assert property (@(posedge mclk)
        disable iff (rst) fetch_trap_irq |-> trap_irq || $past(trap_irq))
        else $error("trap request without trap");
    AST_ST_SET: assert property (@(posedge mclk)
        disable iff (rst) trap_irq |=> stat_reg[fat_pkg::FAT_ST_IRQ])
        else $error("trap status not set");

    // trap reset
    AST_RST_LEN: assert property (@(posedge mclk)
        disable iff (rst)
        $rose(reset_pin_oe) |-> reset_pin_oe [*8] ##[0:20] !reset_pin_oe)
        else $error("trap reset length wrong");
    AST_RST_CAP: assert property (@(posedge mclk)
        disable iff (rst) reset_pin_oe |-> oe_len_reg < RST_LEN)
        else $error("trap reset too long");
    AST_RST_END: assert property (@(posedge mclk)
        disable iff (rst) oe_prev_reg && !reset_pin_oe |-> oe_len_reg == RST_LEN)
        else $error("trap reset ended early");
    AST_PIN_LOW: assert property (@(posedge mclk)
        disable iff (rst) reset_pin_oe |-> !reset_pin_n_o && internal_reset)
        else $error("reset pin not pulled low");
    AST_RST_QUIET: assert property (@(posedge mclk)
        disable iff (rst) in_reset |-> !trap_irq && !trap_rst)
        else $error("trap taken during reset pulse");
    AST_OSC: assert property (@(posedge mclk)
        disable iff (rst) trap_rst && low_speed_mode_one |=> fast_osc_restart)
        else $error("oscillator restart missing");
    AST_OSC_OFF: assert property (@(posedge mclk)
        disable iff (rst) !in_reset && !trap_rst |=> !fast_osc_restart)
        else $error("oscillator restart stuck");

    COV_IRQ: cover property (@(posedge mclk) trap_irq);
    COV_RST: cover property (@(posedge mclk) trap_rst);
    COV_COMMIT: cover property (@(posedge mclk) code_commit ##1 tif.hit_ram);
    COV_OSC: cover property (@(posedge mclk) trap_rst && low_speed_mode_one);
    COV_DIS: cover property (@(posedge mclk) code_dis && !guard_en);
endmodule // fat_top
`default_nettype wire

// [src/fat_pkg.sv]
package fat_pkg;
    localparam logic [7:0] FAT_CODE_COMMIT = 8'hD2;
    localparam logic [7:0] FAT_CODE_CLEAR = 8'h4E;
    localparam logic [7:0] FAT_CODE_DISABLE = 8'hB1;
    // register word addresses (byte address bits 3:2)
    localparam logic [1:0] FAT_ADR_CTRL = 2'h0;
    localparam logic [1:0] FAT_ADR_CODE = 2'h1;
    localparam logic [1:0] FAT_ADR_STAT = 2'h2;
    localparam logic [1:0] FAT_ADR_MASK = 2'h3;
    // guard_control_reg_a field positions
    localparam int FAT_BIT_GEN = 7;
    localparam int FAT_BIT_RAMSEL = 1;
    localparam int FAT_BIT_ACTION = 0;
    localparam logic [7:0] FAT_CTRL_RESET = 8'h80;
    // status bits
    localparam int FAT_ST_IRQ = 0;
    localparam int FAT_ST_RST = 1;
    localparam int FAT_ST_CLR = 2;
    localparam int FAT_ST_W = 3;
    // reset pulse: 24 periods of fc at most
    localparam int FAT_RST_FC_PERIODS = 24;
    localparam int FAT_CLK_MHZ = 200;
    localparam int FAT_FC_MHZ = 200;
    localparam int FAT_RST_CYCLES =
        (FAT_RST_FC_PERIODS * FAT_CLK_MHZ) / FAT_FC_MHZ;
    localparam logic [15:0] FAT_RAM_LO = 16'h0040;
    localparam logic [15:0] FAT_RAM_HI = 16'h043F;
    localparam logic [15:0] FAT_SFR_LO = 16'h0000;
    localparam logic [15:0] FAT_SFR_HI = 16'h003F;
endpackage

// [src/fat_trap_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface fat_trap_if;
    logic fetch_valid;
    logic [15:0] fetch_addr;
    logic ram_trap_select;
    logic hit_sfr;
    logic hit_ram;
    logic trap;
    modport det (input fetch_valid, input fetch_addr,
        input ram_trap_select, output hit_sfr, output hit_ram, output trap);
    modport use_side (output fetch_valid, output fetch_addr,
        output ram_trap_select, input hit_sfr, input hit_ram, input trap);
endinterface
`default_nettype wire

// [src/fat_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module fat_detect (
    fat_trap_if.det t
);
    // purely combinational so a trap flags in the fetch cycle
    assign t.hit_sfr = t.fetch_valid && t.fetch_addr >= fat_pkg::FAT_SFR_LO
        && t.fetch_addr <= fat_pkg::FAT_SFR_HI;
    assign t.hit_ram = t.fetch_valid && t.fetch_addr >= fat_pkg::FAT_RAM_LO
        && t.fetch_addr <= fat_pkg::FAT_RAM_HI;
    assign t.trap = t.hit_sfr || (t.hit_ram && t.ram_trap_select);
endmodule // fat_detect
`default_nettype wire

// [tb/fat_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fat_cpu_model (
    input wire logic mclk,
    input wire logic trap_in,
    output logic fetch_valid,
    output logic [15:0] fetch_addr
);
    initial begin
        fetch_valid = 1'b0;
        fetch_addr = 16'hFFFF;
    end
    // one opcode fetch; bus shows inverted address once released
    // fetches are spaced and never nest traps deeply
    task automatic fetch(input logic [15:0] a, output logic hit);
        @(posedge mclk);
        fetch_valid <= 1'b1;
        fetch_addr <= a;
        @(posedge mclk);
        hit = trap_in;
        fetch_valid <= 1'b0;
        fetch_addr <= ~a;
    endtask
endmodule // fat_cpu_model
`default_nettype wire

// [tb/fat_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module fat_top_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, q;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, fv, lsm = 1'b0;
    logic [15:0] fa;
    logic tirq, pin_n, pin_oe, irst, osc, gclr, grun, irq, h, a;
    int bad_count = 0, n_checks = 0, n_clr = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (gclr === 1'b1) n_clr++;
    fat_cpu_model u_cpu (.mclk(mclk), .trap_in(tirq), .fetch_valid(fv),
        .fetch_addr(fa));
    fat_top u_dut (.mclk(mclk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .fetch_valid(fv), .fetch_addr(fa),
        .low_speed_mode_one(lsm), .fetch_trap_irq(tirq),
        .reset_pin_n_o(pin_n), .reset_pin_oe(pin_oe), .internal_reset(irst),
        .fast_osc_restart(osc), .guard_counter_clear(gclr),
        .guard_running(grun), .irq(irq));
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [1:0] ad, input logic [7:0] d);
        int i;
        i = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {28'h0, ad, 2'h0};
        dat <= {24'h0, d};
        do @(posedge mclk); while (ack !== 1'b1 && ++i < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i >= 20) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic t_reset;
        chk("run", 1, grun);
        chk("oe", 0, pin_oe);
        wb(0, fat_pkg::FAT_ADR_CTRL, 8'h00);
        chk("ctrl rd", 0, q);
    endtask
    task automatic t_sfr;
        wb(1, fat_pkg::FAT_ADR_CTRL, 8'h80);
        u_cpu.fetch(16'h003F, h);
        chk("sfr trap", 1, h);
        u_cpu.fetch(16'h0040, h);
        chk("ram off", 0, h);
        wb(0, fat_pkg::FAT_ADR_STAT, 8'h00);
        chk("stat", 1, q[0]);
        wb(1, fat_pkg::FAT_ADR_STAT, 8'h01);
        wb(0, fat_pkg::FAT_ADR_STAT, 8'h00);
        chk("w1c", 0, q[0]);
    endtask
    task automatic t_ram;
        wb(1, fat_pkg::FAT_ADR_CTRL, 8'h82);
        u_cpu.fetch(16'h0100, h);
        chk("uncommitted", 0, h);
        wb(1, fat_pkg::FAT_ADR_CODE, 8'h55);
        u_cpu.fetch(16'h0100, h);
        chk("bad code", 0, h);
        wb(1, fat_pkg::FAT_ADR_CODE, 8'hD2);
        u_cpu.fetch(16'h043F, h);
        chk("ram trap", 1, h);
        u_cpu.fetch(16'h0440, h);
        chk("above ram", 0, h);
    endtask
    task automatic t_codes;
        wb(1, fat_pkg::FAT_ADR_STAT, 8'h07);
        wb(1, fat_pkg::FAT_ADR_MASK, 8'h04);
        wb(1, fat_pkg::FAT_ADR_CODE, 8'h4E);
        wb(0, fat_pkg::FAT_ADR_STAT, 8'h00);
        chk("clear pulses", 1, n_clr);
        chk("clr stat", 1, q[2]);
        chk("irq on", 1, irq);
        wb(1, fat_pkg::FAT_ADR_MASK, 8'h00);
        chk("mask", 0, irq);
        wb(1, fat_pkg::FAT_ADR_MASK, 8'h04);
        wb(1, fat_pkg::FAT_ADR_STAT, 8'h04);
        wb(0, fat_pkg::FAT_ADR_STAT, 8'h00);
        chk("irq off", 0, irq);
        wb(1, fat_pkg::FAT_ADR_CODE, 8'hB1);
        wb(0, fat_pkg::FAT_ADR_STAT, 8'h00);
        chk("run en", 1, grun);
        wb(1, fat_pkg::FAT_ADR_CTRL, 8'h02);
        wb(1, fat_pkg::FAT_ADR_CODE, 8'hB1);
        wb(0, fat_pkg::FAT_ADR_STAT, 8'h00);
        chk("run off", 0, grun);
    endtask
    task automatic t_trap_rst;
        int n, m;
        n = 0;
        m = 0;
        a = 1'b0;
        lsm <= 1'b1;
        wb(1, fat_pkg::FAT_ADR_CTRL, 8'h03);
        u_cpu.fetch(16'h0010, h);
        chk("no irq", 0, h);
        repeat (60) begin
            @(posedge mclk);
            if (pin_oe === 1'b1) n++;
            if (irst === 1'b1) m++;
            if (osc === 1'b1) a = 1'b1;
        end
        chk("rst len", fat_pkg::FAT_RST_CYCLES, n);
        chk("int rst", fat_pkg::FAT_RST_CYCLES, m);
        chk("pin lvl", 0, pin_n);
        chk("osc", 1, a);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_sfr();
        t_ram();
        t_codes();
        t_trap_rst();
        test_done();
    end
endmodule // fat_top_test
`default_nettype wire
